// *** pim_pkg.sv ***
// Shared constants, register map and carrier types for the process image monitor
package pim_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SPD_EXP = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TOL     = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TMO     = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MASK    = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IMAGE   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_SPD_MEAS = 8'h1c;

  // Widths of the monitor quantities
  localparam int SPD_W  = 16;
  localparam int PCT_W  = 8;
  localparam int SEC_W  = 8;
  localparam int SOCK_W = 4;
  localparam int AREA_W = 8;
  localparam int ST_W   = 2;

  // Process image bit positions in byte 0
  localparam int IN_TRIG_BIT  = 0;
  localparam int IN_AUX_BIT   = 1;
  localparam int IN_PHASE_BIT = 7;
  localparam int OUT1_BIT     = 0;
  localparam int OUT2_BIT     = 1;

  // Status and mask bit positions
  localparam int ST_SPEED = 0;
  localparam int ST_INPUT = 1;

  // Field positions inside the tolerance and image words
  localparam int TOL_ABS_LSB   = 16;
  localparam int IMG_OUT_LSB   = 8;
  localparam int IMG_PINS_LSB  = 16;

  // Reset values
  localparam logic [PCT_W-1:0]  PCT_RST  = 8'h05;
  localparam logic [SPD_W-1:0]  ABS_RST  = 16'h0000;
  localparam logic [SPD_W-1:0]  EXP_RST  = 16'h0000;
  localparam logic [SEC_W-1:0]  TMO_RST  = 8'h03;
  localparam logic [SOCK_W-1:0] SOCK_RST = 4'h4;

  // Percentage scale
  localparam int PCT_SCALE = 100;

  // Time base: one second counted in reference clock cycles
  localparam int ONE_SEC_NS     = 1000000000;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CYC_PER_SEC_DEF = ONE_SEC_NS / CLK_PERIOD_NS;

  // Control register layout, top bit first, down to fb_en in bit 0
  typedef struct packed {
    logic [SOCK_W-1:0] socket;
    logic              check_abs;
    logic              mon_en;
    logic              out2_ctl;
    logic              out1_ctl;
    logic              phase_echo;
    logic              aux_echo;
    logic              trig_echo;
    logic              fb_en;
  } pim_ctrl_t;

  // Kinds of monitor report
  typedef enum logic [1:0] {
    PIM_ERR_NONE,
    PIM_ERR_SPEED,
    PIM_ERR_INPUT
  } pim_err_t;

  // Report handed to the network side
  typedef struct packed {
    logic [SOCK_W-1:0] socket;
    pim_err_t          code;
  } pim_report_t;

endpackage : pim_pkg

// *** pim_speed_chk.sv ***
// Conveyor speed comparison against percentage or absolute tolerance
`timescale 1ns/100ps
`default_nettype none
module pim_speed_chk (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     enable,
  input  wire logic                     check_abs,
  input  wire logic                     sample_vld,
  input  wire logic [pim_pkg::SPD_W-1:0] meas,
  input  wire logic [pim_pkg::SPD_W-1:0] expected,
  input  wire logic [pim_pkg::PCT_W-1:0] pct_tol,
  input  wire logic [pim_pkg::SPD_W-1:0] abs_tol,
  output logic                          err_pulse
);
  import pim_pkg::*;

  typedef struct packed {
    logic err;
  } pim_spd_state_t;

  pim_spd_state_t st_reg, st_next;
  logic [SPD_W-1:0]   diff;
  logic [SPD_W+7:0]   diff_scaled;
  logic [SPD_W+7:0]   allowed;

  // Deviation scaled by 100 against tolerance times expected avoids a divider
  always_comb begin
    diff        = (meas > expected) ? meas - expected : expected - meas;
    diff_scaled = (SPD_W+8)'(diff) * (SPD_W+8)'(PCT_SCALE);
    allowed     = (SPD_W+8)'(pct_tol) * (SPD_W+8)'(expected);
    st_next.err = 1'b0;
    if (enable && sample_vld) begin
      if (check_abs) begin
        st_next.err = diff > abs_tol;
      end else begin
        st_next.err = diff_scaled > allowed;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign err_pulse = st_reg.err;
endmodule : pim_speed_chk
`default_nettype wire

// *** pim_input_tmo.sv ***
// Input health timer: flags an input held active beyond the timeout
`timescale 1ns/100ps
`default_nettype none
module pim_input_tmo #(
  parameter int CYC_PER_SEC = pim_pkg::CYC_PER_SEC_DEF
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     enable,
  input  wire logic                     watched,
  input  wire logic [pim_pkg::SEC_W-1:0] timeout_sec,
  output logic                          err_pulse
);
  import pim_pkg::*;

  localparam int PRE_W = $clog2(CYC_PER_SEC + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_SEC - 1);

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [SEC_W-1:0] secs;
    logic             flagged;
    logic             err;
  } pim_tmo_state_t;

  pim_tmo_state_t st_reg, st_next;

  // Timing restarts whenever the input drops, so only a stuck input reports
  always_comb begin
    st_next     = st_reg;
    st_next.err = 1'b0;
    if (!enable || !watched || timeout_sec == '0) begin
      st_next.pre     = '0;
      st_next.secs    = '0;
      st_next.flagged = 1'b0;
    end else if (!st_reg.flagged) begin
      if (st_reg.secs >= timeout_sec) begin
        st_next.err     = 1'b1;
        st_next.flagged = 1'b1;
      end else if (st_reg.pre == PRE_LAST) begin
        st_next.pre  = '0;
        st_next.secs = st_reg.secs + 1'b1;
      end else begin
        st_next.pre = st_reg.pre + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign err_pulse = st_reg.err;
endmodule : pim_input_tmo
`default_nettype wire

// *** pim_io_monitor.sv ***
// Process image mapping of scanner I/O with speed and input health monitor
//
// Notes on behaviour
// - Trigger echo puts trigger into bit 0
// - Aux echo puts input 3 into bit 1
// - Phase echo shows reading phase in bit 7
// - Output 1 follows output byte bit 0
// - Output 2 follows output byte bit 1
// - Speed check is percentage or absolute
// - Percent mode errors beyond percent tolerance
// - Absolute mode errors beyond absolute tolerance
// - Trigger input checked after timeout, errors reported
// - Reports go out on configured socket
`timescale 1ns/100ps
`default_nettype none
module pim_io_monitor #(
  parameter int CYC_PER_SEC = pim_pkg::CYC_PER_SEC_DEF
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Register port
  input  wire logic [pim_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pim_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [pim_pkg::DATA_W-1:0] reg_rdata,
  output logic                            irq,
  // Scanner side pins
  input  wire logic                       trig_in,
  input  wire logic                       aux_in,
  input  wire logic                       phase_active,
  output logic                            dig_out1,
  output logic                            dig_out2,
  // Fieldbus process image, byte 0 of each area
  input  wire logic                       pi_out_wr,
  input  wire logic [pim_pkg::AREA_W-1:0] pi_out_byte,
  output logic      [pim_pkg::AREA_W-1:0] pi_in_byte,
  // Conveyor speed samples
  input  wire logic                       speed_vld,
  input  wire logic [pim_pkg::SPD_W-1:0]  speed_meas,
  // Monitor report channel
  output logic                            rpt_vld,
  output pim_pkg::pim_report_t            rpt
);
  import pim_pkg::*;

  // Whole module state
  typedef struct packed {
    pim_ctrl_t          ctrl;
    logic [SPD_W-1:0]   spd_exp;
    logic [PCT_W-1:0]   pct_tol;
    logic [SPD_W-1:0]   abs_tol;
    logic [SEC_W-1:0]   tmo_sec;
    logic [ST_W-1:0]    status;
    logic [ST_W-1:0]    mask;
    logic [AREA_W-1:0]  out_area;
    logic [SPD_W-1:0]   last_meas;
    logic [AREA_W-1:0]  in_area;
    logic               out1;
    logic               out2;
    logic [DATA_W-1:0]  rdata;
    logic               irq;
    logic               inp_pend;
    logic               rpt_vld;
    pim_report_t        rpt;
  } pim_state_t;

  pim_state_t st_reg, st_next;

  logic             spd_err;
  logic             inp_err;
  logic             wr_hit_status;
  logic [ST_W-1:0]  st_set;
  logic [ST_W-1:0]  st_clr;

  // Speed deviation checker
  pim_speed_chk u_speed_chk (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .enable     (st_reg.ctrl.mon_en),
    .check_abs  (st_reg.ctrl.check_abs),
    .sample_vld (speed_vld),
    .meas       (speed_meas),
    .expected   (st_reg.spd_exp),
    .pct_tol    (st_reg.pct_tol),
    .abs_tol    (st_reg.abs_tol),
    .err_pulse  (spd_err)
  );

  // Stuck trigger input watchdog
  pim_input_tmo #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_input_tmo (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .enable      (st_reg.ctrl.mon_en),
    .watched     (trig_in),
    .timeout_sec (st_reg.tmo_sec),
    .err_pulse   (inp_err)
  );

  // Status sources and write-one-to-clear terms
  always_comb begin
    st_set           = '0;
    st_set[ST_SPEED] = spd_err;
    st_set[ST_INPUT] = inp_err;
    wr_hit_status    = reg_wr && (reg_addr == ADDR_STATUS);
    st_clr           = wr_hit_status ? reg_wdata[ST_W-1:0] : '0;
  end

  // Next state: registers, image mapping, interrupt and reports
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = '0;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          st_next.ctrl = reg_wdata[$bits(pim_ctrl_t)-1:0];
        end
        ADDR_SPD_EXP: begin
          st_next.spd_exp = reg_wdata[SPD_W-1:0];
        end
        ADDR_TOL: begin
          st_next.pct_tol = reg_wdata[PCT_W-1:0];
          st_next.abs_tol = reg_wdata[TOL_ABS_LSB +: SPD_W];
        end
        ADDR_TMO: begin
          st_next.tmo_sec = reg_wdata[SEC_W-1:0];
        end
        ADDR_MASK: begin
          st_next.mask = reg_wdata[ST_W-1:0];
        end
        default: begin
          st_next.ctrl = st_reg.ctrl;
        end
      endcase
    end

    // Sticky status: a new event beats a clear in the same cycle
    st_next.status = (st_reg.status & ~st_clr) | st_set;

    // Keep the last speed sample for software inspection
    if (speed_vld) begin
      st_next.last_meas = speed_meas;
    end

    // Client writes to the output area only land while mapping is on
    if (pi_out_wr && st_reg.ctrl.fb_en) begin
      st_next.out_area = pi_out_byte;
    end

    // Input area echoes; each bit stays zero while its echo is off
    st_next.in_area = '0;
    if (st_reg.ctrl.fb_en) begin
      st_next.in_area[IN_TRIG_BIT]  = st_reg.ctrl.trig_echo & trig_in;
      st_next.in_area[IN_AUX_BIT]   = st_reg.ctrl.aux_echo & aux_in;
      st_next.in_area[IN_PHASE_BIT] = st_reg.ctrl.phase_echo & phase_active;
    end

    // Scanner outputs fall back to inactive when control is withdrawn
    st_next.out1 = st_reg.ctrl.fb_en & st_reg.ctrl.out1_ctl
                   & st_next.out_area[OUT1_BIT];
    st_next.out2 = st_reg.ctrl.fb_en & st_reg.ctrl.out2_ctl
                   & st_next.out_area[OUT2_BIT];

    // Level interrupt while any unmasked status bit is set
    st_next.irq = |(st_next.status & st_next.mask);

    // Reports: speed takes the slot, a coinciding input error waits for the next cycle without a speed error
    st_next.rpt_vld = 1'b0;
    st_next.rpt     = st_reg.rpt;
    if (spd_err) begin
      st_next.rpt_vld     = 1'b1;
      st_next.rpt.code    = PIM_ERR_SPEED;
      st_next.rpt.socket  = st_reg.ctrl.socket;
      st_next.inp_pend    = st_reg.inp_pend | inp_err;
    end else if (inp_err || st_reg.inp_pend) begin
      st_next.rpt_vld     = 1'b1;
      st_next.rpt.code    = PIM_ERR_INPUT;
      st_next.rpt.socket  = st_reg.ctrl.socket;
      st_next.inp_pend    = 1'b0;
    end

    // Register reads answer in the next cycle only
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          st_next.rdata = DATA_W'(st_reg.ctrl);
        end
        ADDR_SPD_EXP: begin
          st_next.rdata = DATA_W'(st_reg.spd_exp);
        end
        ADDR_TOL: begin
          st_next.rdata[PCT_W-1:0]             = st_reg.pct_tol;
          st_next.rdata[TOL_ABS_LSB +: SPD_W]  = st_reg.abs_tol;
        end
        ADDR_TMO: begin
          st_next.rdata = DATA_W'(st_reg.tmo_sec);
        end
        ADDR_STATUS: begin
          st_next.rdata = DATA_W'(st_reg.status);
        end
        ADDR_MASK: begin
          st_next.rdata = DATA_W'(st_reg.mask);
        end
        ADDR_IMAGE: begin
          st_next.rdata[AREA_W-1:0]          = st_reg.in_area;
          st_next.rdata[IMG_OUT_LSB +: AREA_W] = st_reg.out_area;
          st_next.rdata[IMG_PINS_LSB]        = st_reg.out1;
          st_next.rdata[IMG_PINS_LSB + 1]    = st_reg.out2;
        end
        ADDR_SPD_MEAS: begin
          st_next.rdata = DATA_W'(st_reg.last_meas);
        end
        default: begin
          st_next.rdata = '0; // Unmapped reads return zero
        end
      endcase
    end
  end

  // State register with documented defaults
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg             <= '0;
      st_reg.ctrl.socket <= SOCK_RST;
      st_reg.spd_exp     <= EXP_RST;
      st_reg.pct_tol     <= PCT_RST;
      st_reg.abs_tol     <= ABS_RST;
      st_reg.tmo_sec     <= TMO_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata  = st_reg.rdata;
  assign irq        = st_reg.irq;
  assign dig_out1   = st_reg.out1;
  assign dig_out2   = st_reg.out2;
  assign pi_in_byte = st_reg.in_area;
  assign rpt_vld    = st_reg.rpt_vld;
  assign rpt        = st_reg.rpt;

endmodule : pim_io_monitor
`default_nettype wire

// *** pim_io_monitor_props.sv ***
// Port-level assertions for the process image monitor
`timescale 1ns/100ps
`default_nettype none
module pim_io_monitor_props
  import pim_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              reg_wr,
  input wire logic              trig_in,
  input wire logic              aux_in,
  input wire logic              phase_active,
  input wire logic              dig_out1,
  input wire logic              dig_out2,
  input wire logic              pi_out_wr,
  input wire logic [AREA_W-1:0] pi_out_byte,
  input wire logic [AREA_W-1:0] pi_in_byte,
  input wire logic              speed_vld,
  input wire logic              rpt_vld,
  input wire pim_report_t       rpt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // An echo bit may only show a pin that was high one cycle before
  a_trig_echo_src: assert property (pi_in_byte[0] |-> $past(trig_in))
    else $error("trigger echo without trigger");
  a_aux_echo_src: assert property (!aux_in |=> !pi_in_byte[1])
    else $error("aux echo without aux input");
  a_phase_echo_src: assert property (pi_in_byte[7] |-> $past(phase_active))
    else $error("phase echo without reading phase");
  a_spare_bits_zero: assert property (pi_in_byte[6:2] == 5'h00)
    else $error("unused input area bits not zero");
  // Outputs rise only after a client write or a control change
  a_out1_rise: assert property ($rose(dig_out1) |->
    $past(pi_out_wr && pi_out_byte[0]) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("output 1 rose without cause");
  a_out2_rise: assert property (dig_out2 && !$past(dig_out2) |->
    $past(pi_out_wr && pi_out_byte[1]) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("output 2 rose without cause");
  // Speed report lands two cycles after its sample
  a_speed_rpt_lat: assert property (rpt_vld && rpt.code == PIM_ERR_SPEED
    |-> $past(speed_vld, 2))
    else $error("speed report without sample two cycles before");
  a_input_rpt_src: assert property (rpt_vld && rpt.code == PIM_ERR_INPUT
    |-> $past(trig_in, 2) || $past(trig_in, 3) || $past(trig_in, 4))
    else $error("input report without held trigger");
  a_rpt_code_valid: assert property (rpt_vld
    |-> rpt.code inside {PIM_ERR_SPEED, PIM_ERR_INPUT})
    else $error("report carries no error kind");
endmodule : pim_io_monitor_props
`default_nettype wire

// *** pim_client.sv ***
// Behavioural network client that writes the output area
`timescale 1ns/100ps
`default_nettype none
module pim_client (
  input  wire logic                      ref_clk,
  output var  logic                      pi_out_wr,
  output var  logic [pim_pkg::AREA_W-1:0] pi_out_byte
);
  initial begin
    pi_out_wr = 1'b0;
    pi_out_byte = 8'h00;
  end

  // Gap lets the client answer late; data is scrambled once released
  task automatic put(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    pi_out_wr <= 1'b1;
    pi_out_byte <= b;
    @(posedge ref_clk);
    pi_out_wr <= 1'b0;
    pi_out_byte <= ~b;
  endtask : put
endmodule : pim_client
`default_nettype wire

// *** pim_io_monitor_tb.sv ***
// Self-checking testbench for the process image monitor
`timescale 1ns/100ps
`default_nettype none
module pim_io_monitor_tb;
  import pim_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              irq, dig_out1, dig_out2, pi_out_wr, rpt_vld;
  logic              trig_in = 1'b0;
  logic              aux_in = 1'b0;
  logic              phase_active = 1'b0;
  logic              speed_vld = 1'b0;
  logic [SPD_W-1:0]  speed_meas = 16'h0;
  logic [AREA_W-1:0] pi_out_byte, pi_in_byte;
  pim_report_t       rpt;
  pim_report_t       last_rpt = '0;
  int                n_fail = 0;
  int                checked = 0;
  int                n_rpt = 0;
  int                base;
  logic [7:0]        echo_exp [3] = '{8'h01, 8'h02, 8'h80};

  always #4 ref_clk = ~ref_clk;

  pim_io_monitor #(.CYC_PER_SEC(10)) pim_io_monitor_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .trig_in(trig_in), .aux_in(aux_in), .phase_active(phase_active),
    .dig_out1(dig_out1), .dig_out2(dig_out2), .pi_out_wr(pi_out_wr),
    .pi_out_byte(pi_out_byte), .pi_in_byte(pi_in_byte), .speed_vld(speed_vld),
    .speed_meas(speed_meas), .rpt_vld(rpt_vld), .rpt(rpt));

  pim_client pim_client_i (.ref_clk(ref_clk), .pi_out_wr(pi_out_wr),
    .pi_out_byte(pi_out_byte));

  // Count reports and keep the latest
  always @(posedge ref_clk) begin
    if (rpt_vld === 1'b1) begin
      n_rpt++;
      last_rpt = rpt;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    // Read data must fall back to zero one cycle later
    @(posedge ref_clk);
    #1 chk(reg_rdata, 32'h0);
  endtask : rdchk

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  // One speed sample, then time for the report to land
  task automatic sp(input logic [15:0] v);
    @(posedge ref_clk);
    speed_vld <= 1'b1;
    speed_meas <= v;
    @(posedge ref_clk);
    speed_vld <= 1'b0;
    settle(3);
  endtask : sp

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Watchdog, well beyond the roughly 150 cycles the tests need
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    // Reset values and an unmapped address
    rdchk(ADDR_CTRL, 32'h400);
    rdchk(ADDR_TOL, 32'h5);
    rdchk(ADDR_TMO, 32'h3);
    rdchk(ADDR_STATUS, 32'h0);
    rdchk(ADDR_MASK, 32'h0);
    rdchk(8'h20, 32'h0);
    $display("test reset_values done");
    // Nothing maps while the fieldbus is off
    wr(ADDR_CTRL, 32'h43e);
    @(posedge ref_clk);
    trig_in <= 1'b1;
    aux_in <= 1'b1;
    phase_active <= 1'b1;
    pim_client_i.put(8'h03, 0);
    settle(2);
    chk(32'(pi_in_byte), 32'h0);
    chk(32'({dig_out2, dig_out1}), 32'h0);
    wr(ADDR_CTRL, 32'h43f);
    settle(2);
    chk(32'(pi_in_byte), 32'h83);
    chk(32'({dig_out2, dig_out1}), 32'h0);
    pim_client_i.put(8'h03, 0);
    settle(1);
    chk(32'({dig_out2, dig_out1}), 32'h3);
    pim_client_i.put(8'h02, 3);
    settle(1);
    chk(32'({dig_out2, dig_out1}), 32'h2);
    rdchk(ADDR_IMAGE, 32'h00020283);
    wr(ADDR_CTRL, 32'h40f);
    settle(2);
    chk(32'({dig_out2, dig_out1}), 32'h0);
    $display("test mapping done");
    // Each echo alone, others must read zero
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, 32'h401 | (32'h2 << i));
      settle(2);
      chk(32'(pi_in_byte), 32'(echo_exp[i]));
    end
    @(posedge ref_clk);
    trig_in <= 1'b0;
    aux_in <= 1'b0;
    phase_active <= 1'b0;
    $display("test echo done");
    // Percent mode at the tolerance edge, then absolute mode
    wr(ADDR_SPD_EXP, 32'd1000);
    wr(ADDR_MASK, 32'h3);
    wr(ADDR_CTRL, 32'h441);
    sp(16'd1050);
    chk(n_rpt, 0);
    chk(32'(irq), 32'h0);
    sp(16'd1051);
    chk(n_rpt, 1);
    chk(32'(last_rpt), 32'({4'h4, PIM_ERR_SPEED}));
    chk(32'(irq), 32'h1);
    rdchk(ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    settle(1);
    chk(32'(irq), 32'h0);
    wr(ADDR_TOL, 32'h00140005);
    wr(ADDR_CTRL, 32'h9c1);
    sp(16'd980);
    chk(n_rpt, 1);
    sp(16'd979);
    chk(n_rpt, 2);
    chk(32'(last_rpt), 32'({4'h9, PIM_ERR_SPEED}));
    rdchk(ADDR_SPD_MEAS, 32'd979);
    rdchk(ADDR_SPD_EXP, 32'd1000);
    wr(ADDR_MASK, 32'h0);
    settle(1);
    chk(32'(irq), 32'h0);
    $display("test speed done");
    // Trigger held past the three second timeout
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_CTRL, 32'h441);
    base = n_rpt;
    @(posedge ref_clk);
    trig_in <= 1'b1;
    settle(25);
    chk(n_rpt, base);
    settle(15);
    chk(n_rpt, base + 1);
    chk(32'(last_rpt), 32'({4'h4, PIM_ERR_INPUT}));
    rdchk(ADDR_STATUS, 32'h2);
    @(posedge ref_clk);
    trig_in <= 1'b0;
    $display("test input_timeout done");
    finish_test();
  end
endmodule : pim_io_monitor_tb

bind pim_io_monitor pim_io_monitor_props pim_io_monitor_props_i (
  .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .trig_in(trig_in),
  .aux_in(aux_in), .phase_active(phase_active), .dig_out1(dig_out1),
  .dig_out2(dig_out2), .pi_out_wr(pi_out_wr), .pi_out_byte(pi_out_byte),
  .pi_in_byte(pi_in_byte), .speed_vld(speed_vld), .rpt_vld(rpt_vld), .rpt(rpt));
`default_nettype wire
